// File: design/rwt_pkg.sv
package rwt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WDOG     = 8'h09;
  localparam logic [7:0] ADDR_FLAGS    = 8'h0f;
  localparam logic [7:0] ADDR_CNT_VAL  = 8'h10;
  localparam logic [7:0] ADDR_CNT_CTRL = 8'h11;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int WD_OSC_FAIL_IRQ_ENABLE_BIT   = 7;
  localparam int WD_MULT_MSB   = 6;
  localparam int WD_MULT_LSB   = 2;
  localparam int WD_RES_MSB    = 1;
  localparam int FLAG_WDF_BIT  = 7;
  localparam int FLAG_TF_BIT   = 3;
  localparam int CTRL_RUN_BIT  = 7;
  localparam int CTRL_PULSE_BIT = 6;
  localparam int CTRL_IE_BIT   = 5;
  localparam int CTRL_SEL_MSB  = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] CTRL_RSVD = 3'h0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RWT_RES_16TH    = 2'h0,
    RWT_RES_QUARTER = 2'h1,
    RWT_RES_ONE     = 2'h2,
    RWT_RES_FOUR    = 2'h3
  } rwt_wd_res_t;

  typedef enum logic [1:0] {
    RWT_SRC_4096 = 2'h0,
    RWT_SRC_64   = 2'h1,
    RWT_SRC_1    = 2'h2,
    RWT_SRC_MIN  = 2'h3
  } rwt_cd_src_t;

  // ----------------------------------------------------------------
  // Divider chain taps, as prescaler bit counts (log2 of crystal cycles)
  // ----------------------------------------------------------------
  localparam int OSC_HZ      = 32768;
  localparam int PRESC_W     = 17;
  localparam int SH_4096     = 3;
  localparam int SH_128      = 8;
  localparam int SH_64       = 9;
  localparam int SH_16       = 11;
  localparam int SH_4        = 13;
  localparam int SH_1        = 15;
  localparam int SH_QUARTER  = 17;
  localparam int SEC_PER_MIN = 60;
  localparam logic [5:0] SEC_LAST = 6'(SEC_PER_MIN - 1);

  // Free-running low time: one source period at 4096 or 64 Hz, half of it for a reload of one; 1/64 s for the 1 Hz and per-minute sources.
  localparam int SLOW_LOW_HZ = 64;
  localparam logic [9:0] LOW_4096      = 10'(OSC_HZ / 4096);
  localparam logic [9:0] LOW_4096_HALF = 10'(OSC_HZ / 8192);
  localparam logic [9:0] LOW_64        = 10'(OSC_HZ / 64);
  localparam logic [9:0] LOW_64_HALF   = 10'(OSC_HZ / 128);
  localparam logic [9:0] LOW_SLOW      = 10'(OSC_HZ / SLOW_LOW_HZ);

endpackage : rwt_pkg

// File: design/rwt_timers.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Watchdog timeout is multiplier times resolution: 1/16, 1/4, 1 or 4 seconds.
// [R2] Watchdog register holds multiplier in D6..D2, resolution in D1..D0, other enable D7.
// [R3] Watchdog not restarted before timeout sets the watchdog timeout flag.
// [R4] Any watchdog register write restarts the timeout; host must write periodically.
// [R5] Watchdog timeout asserts the shared interrupt pin.
// [R6] Writing the watchdog register releases the pin and re-arms with the new value.
// [R7] Writing zero to the lower seven bits releases the pin and disables the watchdog.
// [R8] Flags read clears the watchdog flag but keeps the watchdog pin assertion.
// [R9] Power-up clears the watchdog register, so the watchdog starts disabled.
// [R10] Countdown source select: 4096 Hz, 64 Hz, 1 Hz or one per minute.
// [R11] Counter decrements to 1, then on the next tick reloads and sets the flag.
// [R12] Countdown register writes change only the reload value, not flag or pin.
// [R13] Countdown register reads return the live count.
// [R14] Level mode holds the pin low until a flags read clears the timer flag.
// [R15] Pulse mode: period n source cycles, low one cycle at 4096 or 64 Hz, low 1/64 s at 1 Hz or per minute.
// [R16] Pulse mode with reload one at 4096 or 64 Hz: low half a period.
// [R17] Pulse mode still sets the flag; clearing it does not touch the pin.
// [R18] The pulse starts in the same cycle in which the flag sets.
// [R19] Reload value zero stops the counter; otherwise it keeps counting while the run bit is set.
// [R20] Level mode pin follows flag and enable; re-enabling with flag set asserts again.
// [R21] Power-down clears the run bit; counting resumes from the held count.
// [R22] Flags read clears the timer flag and, in level mode, releases a timer-caused pin assertion.
// [R23] Host writes zero to reserved bits of flags and control registers.
// [R24] Host serial clock must be at least twice the timer source rate.
// [R25] All ticks come from one divider chain fed by the crystal.
module rwt_timers (
  // Clock, reset and enable
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Asynchronous pins
  input  wire logic       osc_clk,
  input  wire logic       vcc_fail,
  // Byte register port from the serial engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Open-drain interrupt pin, pulled low while high
  output logic            shared_interrupt_pin_oe
);
  import rwt_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and crystal edge detect
  // ----------------------------------------------------------------
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic vcc_s1_q, vcc_s2_q;
  wire  osc_rise = osc_s2_q & ~osc_s3_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      vcc_s1_q <= 1'b0;
      vcc_s2_q <= 1'b0;
    end else if (ce) begin
      osc_s1_q <= osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      vcc_s1_q <= vcc_fail;
      vcc_s2_q <= vcc_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  // [R25] one shared chain
  logic [PRESC_W-1:0] presc_q;
  logic [5:0]         sec_q;
  wire t4096 = osc_rise & (&presc_q[SH_4096-1:0]);
  wire t64   = osc_rise & (&presc_q[SH_64-1:0]);
  wire t16   = osc_rise & (&presc_q[SH_16-1:0]);
  wire t4    = osc_rise & (&presc_q[SH_4-1:0]);
  wire t1    = osc_rise & (&presc_q[SH_1-1:0]);
  wire tq    = osc_rise & (&presc_q[SH_QUARTER-1:0]);
  wire tmin  = t1 & (sec_q == SEC_LAST);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
      sec_q   <= '0;
    end else if (ce) begin
      if (osc_rise) presc_q <= presc_q + PRESC_W'(1);
      if (tmin) sec_q <= '0;
      else if (t1) sec_q <= sec_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_wdog  = reg_wr & (reg_addr == ADDR_WDOG);
  wire wr_val   = reg_wr & (reg_addr == ADDR_CNT_VAL);
  wire wr_ctrl  = reg_wr & (reg_addr == ADDR_CNT_CTRL);
  wire rd_flags = reg_rd & (reg_addr == ADDR_FLAGS);

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic       osc_fail_irq_enable_q, wd_live_q, wd_irq_q, wdf_q;
  logic [4:0] wd_mult_q, wd_cnt_q;
  logic [1:0] wd_res_q;
  logic       wd_tick, wd_expire;

  // [R1] resolution tap
  always_comb begin
    unique case (rwt_wd_res_t'(wd_res_q))
      RWT_RES_16TH:    wd_tick = t16;
      RWT_RES_QUARTER: wd_tick = t4;
      RWT_RES_ONE:     wd_tick = t1;
      RWT_RES_FOUR:    wd_tick = tq;
    endcase
  end

  // [R3] timeout detect
  assign wd_expire = wd_live_q & wd_tick & ~wr_wdog & ((wd_cnt_q + 5'h01) == wd_mult_q);

  // The pin flop takes the next watchdog request, so release and timeout reach the pin on the same edge as wd_irq_q.
  wire wd_irq_d = wr_wdog ? 1'b0 : (wd_expire | wd_irq_q);

  // A zero multiplier would mean a zero timeout, so it is treated as disabled.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // [R9] cleared at power-up
      osc_fail_irq_enable_q    <= REG_RESET[WD_OSC_FAIL_IRQ_ENABLE_BIT];
      wd_mult_q <= REG_RESET[WD_MULT_MSB:WD_MULT_LSB];
      wd_res_q  <= REG_RESET[WD_RES_MSB:0];
      wd_cnt_q  <= '0;
      wd_live_q <= 1'b0;
      wd_irq_q  <= 1'b0;
      wdf_q     <= 1'b0;
    end else if (ce) begin
      if (wr_wdog) begin
        // [R2] field split
        osc_fail_irq_enable_q    <= reg_wdata[WD_OSC_FAIL_IRQ_ENABLE_BIT];
        wd_mult_q <= reg_wdata[WD_MULT_MSB:WD_MULT_LSB];
        wd_res_q  <= reg_wdata[WD_RES_MSB:0];
        // [R4] restart on write
        wd_cnt_q  <= '0;
        // [R7] zero disables
        wd_live_q <= |reg_wdata[WD_MULT_MSB:WD_MULT_LSB];
        // [R6] write releases pin
        wd_irq_q  <= 1'b0;
      end else if (wd_expire) begin
        wd_live_q <= 1'b0;
        // [R5] pin on timeout
        wd_irq_q  <= 1'b1;
      end else if (wd_live_q && wd_tick) begin
        wd_cnt_q  <= wd_cnt_q + 5'h01;
      end
      // [R8] read clears flag, set wins
      if (wd_expire) wdf_q <= 1'b1;
      else if (rd_flags) wdf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Countdown timer
  // ----------------------------------------------------------------
  logic [7:0] cd_reload_q, cd_count_q;
  logic       cd_run_q, cd_pm_q, cd_ie_q, tf_q;
  logic [1:0] cd_sel_q;
  logic [9:0] pulse_cnt_q;
  logic       cd_tick;
  logic [9:0] low_len;

  // [R10] source select
  always_comb begin
    unique case (rwt_cd_src_t'(cd_sel_q))
      RWT_SRC_4096: cd_tick = t4096;
      RWT_SRC_64:   cd_tick = t64;
      RWT_SRC_1:    cd_tick = t1;
      RWT_SRC_MIN:  cd_tick = tmin;
    endcase
  end

  // [R16] half low time
  wire reload_one = (cd_reload_q == 8'h01);
  always_comb begin
    unique case (rwt_cd_src_t'(cd_sel_q))
      RWT_SRC_4096: low_len = reload_one ? LOW_4096_HALF : LOW_4096;
      RWT_SRC_64:   low_len = reload_one ? LOW_64_HALF : LOW_64;
      RWT_SRC_1:    low_len = LOW_SLOW;
      RWT_SRC_MIN:  low_len = LOW_SLOW;
    endcase
  end

  // [R19] zero reload stops
  wire cd_active = cd_run_q & (cd_reload_q != 8'h00);
  wire cd_step   = cd_active & cd_tick;
  // [R11] reload at one
  wire cd_evt    = cd_step & (cd_count_q <= 8'h01);

  // Next-state values let the pin flop change on the same edge as the flag.
  logic       tf_d, ie_d, pm_d;
  logic [9:0] pulse_cnt_d;
  logic       pin_d;

  always_comb begin
    // [R22] read clears flag, set wins
    tf_d = cd_evt | (tf_q & ~rd_flags);
    // [R12] value write leaves flag
    ie_d = wr_ctrl ? reg_wdata[CTRL_IE_BIT] : cd_ie_q;
    pm_d = wr_ctrl ? reg_wdata[CTRL_PULSE_BIT] : cd_pm_q;
    pulse_cnt_d = pulse_cnt_q;
    // [R15] low then high
    if (cd_evt && cd_pm_q) pulse_cnt_d = low_len;
    else if (osc_rise && pulse_cnt_q != 10'h000) pulse_cnt_d = pulse_cnt_q - 10'h001;
    // [R17] flag ignored in pulse mode
    // [R20] level gated by enable
    pin_d = wd_irq_d | (pm_d ? (pulse_cnt_d != 10'h000) : (tf_d & ie_d));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cd_reload_q <= REG_RESET;
      cd_count_q  <= REG_RESET;
      cd_run_q    <= REG_RESET[CTRL_RUN_BIT];
      cd_pm_q     <= REG_RESET[CTRL_PULSE_BIT];
      cd_ie_q     <= REG_RESET[CTRL_IE_BIT];
      cd_sel_q    <= REG_RESET[CTRL_SEL_MSB:0];
      tf_q        <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (ce) begin
      // [R12] write sets reload only
      if (wr_val) cd_reload_q <= reg_wdata;
      // [R11] decrement and reload
      if (cd_evt) cd_count_q <= cd_reload_q;
      else if (cd_step) cd_count_q <= cd_count_q - 8'h01;
      // [R21] power-down stops, count held
      if (vcc_s2_q) cd_run_q <= 1'b0;
      else if (wr_ctrl) cd_run_q <= reg_wdata[CTRL_RUN_BIT];
      if (wr_ctrl) cd_sel_q <= reg_wdata[CTRL_SEL_MSB:0];
      cd_pm_q     <= pm_d;
      cd_ie_q     <= ie_d;
      tf_q        <= tf_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // [R14] level hold until read
  // [R18] pulse with flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) shared_interrupt_pin_oe <= 1'b0;
    else if (ce) shared_interrupt_pin_oe <= pin_d;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // [R13] live count readback
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      ADDR_WDOG:     rd_mux = {osc_fail_irq_enable_q, wd_mult_q, wd_res_q};
      ADDR_FLAGS: begin
        rd_mux[FLAG_WDF_BIT] = wdf_q;
        rd_mux[FLAG_TF_BIT]  = tf_q;
      end
      ADDR_CNT_VAL:  rd_mux = cd_count_q;
      ADDR_CNT_CTRL: rd_mux = {cd_run_q, cd_pm_q, cd_ie_q, CTRL_RSVD, cd_sel_q};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 8'h00;
    else if (ce && reg_rd) reg_rdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_wd_timeout;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wd_expire) |=> (wdf_q && wd_irq_q && !wd_live_q);
  endproperty
  a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog timeout not flagged"); // [R3]

  property p_wd_write;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_wdog) |=> (!wd_irq_q && wd_cnt_q == 5'h00 && wd_mult_q == $past(reg_wdata[6:2]));
  endproperty
  a_wd_write: assert property (p_wd_write) else $error("watchdog write did not re-arm"); // [R6]

  property p_wd_zero;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_wdog && reg_wdata[6:0] == 7'h00) |=> (!wd_live_q ##1 !wd_irq_q);
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("zero watchdog write did not disable"); // [R7]

  property p_wdf_read;
    @(posedge mclk) disable iff (!rst_n)
    (ce && rd_flags && !wd_expire && !wr_wdog && wd_irq_q) |=> (!wdf_q && wd_irq_q);
  endproperty
  a_wdf_read: assert property (p_wdf_read) else $error("flags read mishandled watchdog"); // [R8]

  property p_cd_reload;
    @(posedge mclk) disable iff (!rst_n)
    (ce && cd_evt && !wr_val) |=> (cd_count_q == cd_reload_q && tf_q);
  endproperty
  a_cd_reload: assert property (p_cd_reload) else $error("countdown reload missed"); // [R11]

  property p_cd_dec;
    @(posedge mclk) disable iff (!rst_n)
    (ce && cd_step && cd_count_q > 8'h01) |=> (cd_count_q == $past(cd_count_q) - 8'h01);
  endproperty
  a_cd_dec: assert property (p_cd_dec) else $error("countdown did not decrement"); // [R11]

  property p_cd_stop;
    @(posedge mclk) disable iff (!rst_n)
    (cd_reload_q == 8'h00 && !wr_val) |=> $stable(cd_count_q);
  endproperty
  a_cd_stop: assert property (p_cd_stop) else $error("countdown ran with zero reload"); // [R19]

  property p_tf_read;
    @(posedge mclk) disable iff (!rst_n)
    (ce && rd_flags && !cd_evt) |=> !tf_q;
  endproperty
  a_tf_read: assert property (p_tf_read) else $error("flags read left timer flag"); // [R22]

  property p_val_write;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wr_val && !rd_flags && !cd_evt) |=> (tf_q == $past(tf_q));
  endproperty
  a_val_write: assert property (p_val_write) else $error("value write changed flag"); // [R12]

  property p_pulse_start;
    @(posedge mclk) disable iff (!rst_n)
    (ce && cd_evt && cd_pm_q && !wr_ctrl) |=> (tf_q && shared_interrupt_pin_oe);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not with flag"); // [R18]

  property p_level_pin;
    @(posedge mclk) disable iff (!rst_n)
    (!cd_pm_q && !wd_irq_q) |-> (shared_interrupt_pin_oe == (tf_q && cd_ie_q));
  endproperty
  a_level_pin: assert property (p_level_pin) else $error("level pin wrong"); // [R20]

  property p_power_down;
    @(posedge mclk) disable iff (!rst_n)
    (ce && vcc_s2_q) |=> (!cd_run_q ##1 $stable(cd_count_q));
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down kept timer"); // [R21]

  property p_wd_pin;
    @(posedge mclk) disable iff (!rst_n)
    (ce && wd_expire) |=> shared_interrupt_pin_oe;
  endproperty
  a_wd_pin: assert property (p_wd_pin) else $error("watchdog timeout left pin free"); // [R5]

  property p_rd_count;
    @(posedge mclk) disable iff (!rst_n)
    (ce && reg_rd && reg_addr == ADDR_CNT_VAL) |=> (reg_rdata == $past(cd_count_q));
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count read not live"); // [R13]

  property p_pulse_half;
    @(posedge mclk) disable iff (!rst_n)
    (ce && cd_evt && cd_pm_q && cd_sel_q == RWT_SRC_4096 && reload_one)
      |=> (pulse_cnt_q == LOW_4096_HALF);
  endproperty
  a_pulse_half: assert property (p_pulse_half) else $error("reload one pulse not half"); // [R16]

  property p_pulse_free;
    @(posedge mclk) disable iff (!rst_n)
    (cd_pm_q && !wd_irq_q) |-> (shared_interrupt_pin_oe == (pulse_cnt_q != 10'h000));
  endproperty
  a_pulse_free: assert property (p_pulse_free) else $error("pulse pin followed flag"); // [R17]

endmodule : rwt_timers

// File: dv/rwt_far_end.sv
`timescale 1ns/1ps
module rwt_far_end (
  // Interrupt pin from the device
  input  wire logic shared_interrupt_pin_oe,
  // Crystal and wire level
  output logic      osc_clk,
  output logic      int_pin
);
  // ----------------------------------------------------------------
  // Crystal and pull-up
  // ----------------------------------------------------------------
  // The crystal runs free with an offset start, so its edges never line up with mclk.
  initial begin
    osc_clk = 1'b0;
    #37;
    forever #100 osc_clk = ~osc_clk;
  end

  // The pull-up gives a high level whenever the device lets go of the pin.
  assign int_pin = shared_interrupt_pin_oe ? 1'b0 : 1'b1;
endmodule : rwt_far_end

// File: dv/rwt_timers_tb.sv
`timescale 1ns/1ps
module rwt_timers_tb;
  import rwt_pkg::*;

  logic       mclk, rst_n, ce, vcc_fail, reg_wr, reg_rd, osc_clk, int_pin, pin_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, n, c;
  int         err_total, total_checks, low_n, per_n, seed_v, k;
  logic [7:0] amap [5] = '{ADDR_WDOG, ADDR_FLAGS, ADDR_CNT_VAL, ADDR_CNT_CTRL, 8'h20};

  rwt_timers rwt_timers_i (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .osc_clk(osc_clk), .vcc_fail(vcc_fail),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .shared_interrupt_pin_oe(pin_oe));

  rwt_far_end rwt_far_end_i (.shared_interrupt_pin_oe(pin_oe), .osc_clk(osc_clk),
    .int_pin(int_pin));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  task automatic wait_pin(input logic lvl, input int max);
    int t;
    t = 0;
    while (int_pin !== lvl && t < max) begin
      @(negedge mclk);
      t++;
    end
    chk("pin level", lvl, int_pin);
  endtask : wait_pin

  task automatic measure(output int lo, output int per);
    lo = 0;
    wait_pin(1'b1, 20000);
    wait_pin(1'b0, 20000);
    while (int_pin === 1'b0 && lo < 20000) begin
      @(negedge mclk);
      lo++;
    end
    per = lo;
    while (int_pin === 1'b1 && per < 40000) begin
      @(negedge mclk);
      per++;
    end
  endtask : measure

  // One source period in mclk cycles: 8 or 512 crystal cycles of 8 mclk each.
  function automatic int base_cyc(input int s);
    return (s == 0) ? 64 : 4096;
  endfunction : base_cyc

  function automatic int exp_low(input int s, input int nv);
    return (nv == 1) ? base_cyc(s) / 2 : base_cyc(s);
  endfunction : exp_low

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Watchdog on the run itself
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    $display("[ERR] run time expected done seen hang");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    vcc_fail = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    err_total = 0;
    total_checks = 0;
    seed_v = $urandom(32'hbfe2cab1);
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    foreach (amap[i]) begin
      rd(amap[i], rd_v);
      chk("reset value", 8'h00, rd_v);
    end
    chk("pin after reset", 1'b1, int_pin);
    end_test("reset");

    n = 8'($urandom_range(4, 2));
    wr(ADDR_CNT_VAL, n);
    wr(ADDR_CNT_CTRL, 8'ha0);
    rd(ADDR_CNT_CTRL, rd_v);
    chk("ctrl readback", 8'ha0, rd_v);
    wait_pin(1'b0, 64 * 6 + 100);
    rd(ADDR_CNT_VAL, rd_v);
    chk("live count", 1'b1, (rd_v >= 8'h01 && rd_v <= n));
    wr(ADDR_CNT_VAL, n);
    repeat (3) @(negedge mclk);
    chk("pin after reload write", 1'b0, int_pin);
    // Stopping first keeps a fresh reload from setting the flag again under the check.
    wr(ADDR_CNT_CTRL, 8'h20);
    rd(ADDR_FLAGS, rd_v);
    chk("timer flag", 8'h08, rd_v);
    repeat (3) @(negedge mclk);
    chk("pin after flags read", 1'b1, int_pin);
    wr(ADDR_CNT_CTRL, 8'h80);
    repeat (n * 64 + 80) @(negedge mclk);
    chk("pin with enable off", 1'b1, int_pin);
    wr(ADDR_CNT_CTRL, 8'ha0);
    repeat (2) @(negedge mclk);
    chk("pin on re-enable", 1'b0, int_pin);
    rd(ADDR_FLAGS, rd_v);
    chk("flag kept", 8'h08, rd_v);
    end_test("level");

    @(negedge mclk) vcc_fail = 1'b1;
    repeat (6) @(negedge mclk);
    vcc_fail = 1'b0;
    repeat (4) @(negedge mclk);
    rd(ADDR_CNT_CTRL, rd_v);
    chk("run cleared", 8'h20, rd_v);
    // A write while the clock enable is low must not reach the registers.
    ce = 1'b0;
    wr(ADDR_CNT_CTRL, 8'h00);
    ce = 1'b1;
    rd(ADDR_CNT_CTRL, rd_v);
    chk("ctrl frozen", 8'h20, rd_v);
    rd(ADDR_CNT_VAL, c);
    repeat (300) @(negedge mclk);
    rd(ADDR_CNT_VAL, rd_v);
    chk("count held", c, rd_v);
    wr(ADDR_CNT_VAL, 8'h00);
    wr(ADDR_CNT_CTRL, 8'h80);
    repeat (300) @(negedge mclk);
    rd(ADDR_FLAGS, rd_v);
    repeat (600) @(negedge mclk);
    rd(ADDR_FLAGS, rd_v);
    chk("stopped flag", 8'h00, rd_v);
    end_test("hold and stop");

    for (int s = 0; s < 2; s++) begin
      for (int j = 0; j < 2; j++) begin
        n = (j == 0) ? 8'h01 : ((s == 0) ? 8'($urandom_range(3, 2)) : 8'h02);
        wr(ADDR_CNT_VAL, n);
        wr(ADDR_CNT_CTRL, 8'he0 | 8'(s));
        measure(low_n, per_n);
        chk("pulse low", 1'b1, (low_n >= exp_low(s, n) - 1 && low_n <= exp_low(s, n) + 1));
        k = n * base_cyc(s);
        chk("pulse period", 1'b1, (per_n >= k - 1 && per_n <= k + 1));
        rd(ADDR_FLAGS, rd_v);
        chk("pulse flag", 8'h08, rd_v);
      end
    end
    wr(ADDR_CNT_CTRL, 8'h03);
    rd(ADDR_FLAGS, rd_v);
    wait_pin(1'b1, 100);
    end_test("pulse");

    for (int r = 0; r < 4; r++) begin
      n = {1'(r), 5'($urandom_range(31, 1)), 2'(r)};
      wr(ADDR_WDOG, n);
      rd(ADDR_WDOG, rd_v);
      chk("wdog field readback", n, rd_v);
    end
    wr(ADDR_WDOG, 8'h04);
    rd(ADDR_WDOG, rd_v);
    chk("wdog readback", 8'h04, rd_v);
    wait_pin(1'b0, 2048 * 8 + 100);
    rd(ADDR_FLAGS, rd_v);
    chk("wdog flag", 8'h80, rd_v);
    repeat (2) @(negedge mclk);
    chk("pin kept", 1'b0, int_pin);
    rd(ADDR_FLAGS, rd_v);
    chk("wdog flag cleared", 8'h00, rd_v);
    wr(ADDR_WDOG, 8'h08);
    chk("pin released", 1'b1, int_pin);
    k = 0;
    while (int_pin !== 1'b0 && k < 40000) begin
      @(negedge mclk);
      k++;
    end
    chk("wdog span", 1'b1, (k >= 2048 * 8 - 40 && k <= 4096 * 8 + 40));
    rd(ADDR_FLAGS, rd_v);
    chk("wdog flag again", 8'h80, rd_v);
    wr(ADDR_WDOG, 8'h00);
    chk("pin off on zero", 1'b1, int_pin);
    repeat (4000) @(negedge mclk);
    chk("wdog disabled", 1'b1, int_pin);
    rd(ADDR_FLAGS, rd_v);
    chk("wdog flag off", 8'h00, rd_v);
    end_test("watchdog");
    print_verdict();
  end
endmodule : rwt_timers_tb
